// file: verilog/rccr_pkg.sv
// holds register map, reset values, field positions and mode codes of the converter config bank.
// assumes one 20 MHz system clock and byte-wide host access with an address/data flag in bit 7.
package rccr_pkg;

  // ************************************************************
  // clock and excitation
  // ************************************************************
  localparam int SYS_CLK_HZ = 20000000;
  localparam int NCO_WIDTH = 15;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_ANGLE_HI = 8'h80;
  localparam logic [7:0] ADDR_ANGLE_LO = 8'h81;
  localparam logic [7:0] ADDR_SPEED_HI = 8'h82;
  localparam logic [7:0] ADDR_SPEED_LO = 8'h83;
  localparam logic [7:0] ADDR_SIG_LOSS = 8'h88;
  localparam logic [7:0] ADDR_OVERRANGE = 8'h89;
  localparam logic [7:0] ADDR_MISMATCH = 8'h8A;
  localparam logic [7:0] ADDR_MON_MAX = 8'h8B;
  localparam logic [7:0] ADDR_MON_MIN = 8'h8C;
  localparam logic [7:0] ADDR_TRK_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_TRK_LOW = 8'h8E;
  localparam logic [7:0] ADDR_EXC_FREQ = 8'h91;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h92;
  localparam logic [7:0] ADDR_SOFT_RST = 8'hF0;
  localparam logic [7:0] ADDR_FAULT = 8'hFF;

  // ************************************************************
  // read/write bank layout and power-up values
  // ************************************************************
  localparam int RW_COUNT = 9;
  localparam logic [3:0] IDX_EXC_FREQ = 4'h7;
  localparam logic [3:0] IDX_MODE_CTRL = 4'h8;
  localparam logic [6:0] RST_SIG_LOSS = 7'h3A;   // 58 steps of 38 mV
  localparam logic [6:0] RST_OVERRANGE = 7'h6C;  // 108 steps of 38 mV
  localparam logic [6:0] RST_MISMATCH = 7'h0A;   // 10 steps of 38 mV
  localparam logic [6:0] RST_MON_MAX = 7'h3C;
  localparam logic [6:0] RST_MON_MIN = 7'h69;
  localparam logic [6:0] RST_TRK_HIGH = 7'h24;
  localparam logic [6:0] RST_TRK_LOW = 7'h07;
  localparam logic [6:0] RST_EXC_FREQ = 7'h28;   // 10 kHz at 8.192 MHz
  localparam logic [6:0] RST_MODE_CTRL = 7'h7E;
  localparam logic [RW_COUNT-1:0][6:0] RW_RESET = {RST_MODE_CTRL, RST_EXC_FREQ, RST_TRK_LOW, RST_TRK_HIGH,
    RST_MON_MIN, RST_MON_MAX, RST_MISMATCH, RST_OVERRANGE, RST_SIG_LOSS};

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int TYPE_BIT = 7;
  localparam int PARITY_BIT = 7;
  localparam int CTRL_HYST_BIT = 4;
  localparam int CTRL_RES_HI_BIT = 1;
  localparam int CTRL_RES_LO_BIT = 0;
  localparam int FLT_CLIP = 7;
  localparam int FLT_LOSS = 6;
  localparam int FLT_OVER = 5;
  localparam int FLT_MISM = 4;
  localparam int FLT_TRACK = 3;
  localparam int FLT_PHASE = 1;
  localparam int FLT_PARITY = 0;

  // ************************************************************
  // modes and resolution codes ({lo, hi} pin order)
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_POS = 2'h0,
    MODE_VEL = 2'h1,
    MODE_RSV = 2'h2,
    MODE_CFG = 2'h3
  } rccr_mode_t;

  localparam logic [1:0] RES_10 = 2'h0;
  localparam logic [1:0] RES_12 = 2'h1;
  localparam logic [1:0] RES_14 = 2'h2;
  localparam logic [1:0] RES_16 = 2'h3;
  localparam logic [15:0] MASK_10 = 16'hFFC0;
  localparam logic [15:0] MASK_12 = 16'hFFF0;
  localparam logic [15:0] MASK_14 = 16'hFFFC;
  localparam logic [15:0] MASK_16 = 16'hFFFF;

  // position mask that keeps only the valid top bits of a resolution
  function automatic logic [15:0] rccr_res_mask(input logic [1:0] code);
    case (code)
      RES_10: rccr_res_mask = MASK_10;
      RES_12: rccr_res_mask = MASK_12;
      RES_14: rccr_res_mask = MASK_14;
      default: rccr_res_mask = MASK_16;
    endcase
  endfunction : rccr_res_mask

  // maps an address onto the read/write bank: {hit, index}
  function automatic logic [4:0] rccr_rw_index(input logic [7:0] addr);
    case (addr)
      ADDR_SIG_LOSS: rccr_rw_index = 5'h10;
      ADDR_OVERRANGE: rccr_rw_index = 5'h11;
      ADDR_MISMATCH: rccr_rw_index = 5'h12;
      ADDR_MON_MAX: rccr_rw_index = 5'h13;
      ADDR_MON_MIN: rccr_rw_index = 5'h14;
      ADDR_TRK_HIGH: rccr_rw_index = 5'h15;
      ADDR_TRK_LOW: rccr_rw_index = 5'h16;
      ADDR_EXC_FREQ: rccr_rw_index = {1'b1, IDX_EXC_FREQ};
      ADDR_MODE_CTRL: rccr_rw_index = {1'b1, IDX_MODE_CTRL};
      default: rccr_rw_index = 5'h00;
    endcase
  endfunction : rccr_rw_index

endpackage : rccr_pkg

// file: verilog/rccr_exc_nco.sv
// holds the excitation phase accumulator that turns the frequency word into a square reference.
// assumes the word is steady between host writes and restart is a one-cycle pulse.
`timescale 1ns/1ps
module rccr_exc_nco
  import rccr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [6:0] frequency_control_word,
  output logic excitation_out
);

  typedef struct packed {
    logic [NCO_WIDTH-1:0] acc;
    logic exc;
  } rccr_nco_t;

  rccr_nco_t st_r;
  rccr_nco_t st_nxt;

  // msb of a 2^15 accumulator stepping by the word toggles at word * clk / 2^15
  always_comb begin
    st_nxt = st_r;
    if (restart) begin
      st_nxt.acc = '0;
    end else begin
      st_nxt.acc = st_r.acc + {{(NCO_WIDTH-7){1'b0}}, frequency_control_word};
    end
    st_nxt.exc = st_nxt.acc[NCO_WIDTH-1];
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign excitation_out = st_r.exc;

  nco_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !restart |=> st_r.acc == NCO_WIDTH'($past(st_r.acc) + $past(frequency_control_word)))
    else $error("accumulator did not advance by the frequency word");

endmodule : rccr_exc_nco

// file: verilog/rccr_top.sv
// holds the mode decode, configuration bank, sample snapshots and fault latches of the converter.
// assumes mode, resolution and sample pins are asynchronous; host bytes, angle, speed and
// fault events come from logic on sys_clk.
`timescale 1ns/1ps
module rccr_top
  import rccr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mode_select_lo,
  input wire logic mode_select_hi,
  input wire logic resolution_select_lo,
  input wire logic resolution_select_hi,
  input wire logic sample_n,
  input wire logic [15:0] angle_in,
  input wire logic [15:0] speed_in,
  input wire logic [7:0] fault_event,
  input wire logic host_wr_valid,
  input wire logic [7:0] host_wr_byte,
  input wire logic host_rd_req,
  output logic [7:0] host_rd_data,
  output logic host_rd_valid,
  output logic [15:0] data_out,
  output logic [1:0] resolution_code,
  output logic config_mode,
  output logic signal_degradation_n,
  output logic tracking_loss_n,
  output logic excitation_out
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic [1:0] res_s1;
    logic [1:0] res_s2;
    logic smp_s1;
    logic smp_s2;
    logic smp_d;
    logic [7:0] addr;
    logic [RW_COUNT-1:0][7:0] bank;
    logic [15:0] pos;
    logic [15:0] vel;
    logic [7:0] lo_hold;
    logic lo_pend;
    logic lo_is_speed;
    logic [7:0] fault;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [15:0] dout;
    logic [1:0] res;
    logic cfg;
    logic degrade_n;
    logic track_n;
    logic soft_rst;
  } rccr_state_t;

  rccr_state_t st_r;
  rccr_state_t st_nxt;

  logic is_cfg;
  logic smp_fall;
  logic [4:0] wr_hit;
  logic [4:0] rd_hit;
  logic [1:0] res_live;
  logic par_err;
  logic flt_clear;
  logic [7:0] ctrl_byte;
  logic [7:0] sel_byte;

  // ************************************************************
  // decode of synchronised pins and current address
  // ************************************************************
  // reserved code falls through to position output with no config access
  assign is_cfg = rccr_mode_t'(st_r.mode_s2) == MODE_CFG;
  assign smp_fall = st_r.smp_d & ~st_r.smp_s2;
  assign wr_hit = rccr_rw_index(st_r.addr);
  assign rd_hit = rccr_rw_index(st_r.addr);
  assign ctrl_byte = st_r.bank[IDX_MODE_CTRL];
  assign sel_byte = st_r.bank[rd_hit[3:0]];
  // control bits rule in configuration, pins otherwise; a mismatch is the host's problem
  assign res_live = is_cfg ? {ctrl_byte[CTRL_RES_LO_BIT], ctrl_byte[CTRL_RES_HI_BIT]} : st_r.res_s2;
  assign flt_clear = host_rd_req & is_cfg & (st_r.addr == ADDR_FAULT);

  // stored parity is checked every cycle so a corrupted entry raises the fault bit
  always_comb begin
    par_err = 1'b0;
    for (int i = 0; i < RW_COUNT; i++) begin
      par_err = par_err | (st_r.bank[i][PARITY_BIT] ^ (^st_r.bank[i][6:0]));
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    // two-stage synchronisers; only the second stage is looked at
    st_nxt.mode_s1 = {mode_select_lo, mode_select_hi};
    st_nxt.mode_s2 = st_r.mode_s1;
    st_nxt.res_s1 = {resolution_select_lo, resolution_select_hi};
    st_nxt.res_s2 = st_r.res_s1;
    st_nxt.smp_s1 = sample_n;
    st_nxt.smp_s2 = st_r.smp_s1;
    st_nxt.smp_d = st_r.smp_s2;
    st_nxt.soft_rst = 1'b0;
    st_nxt.rd_valid = 1'b0;
    st_nxt.res = res_live;
    st_nxt.cfg = is_cfg;

    // host byte: flag bit picks address or data
    if (host_wr_valid) begin
      if (host_wr_byte[TYPE_BIT]) begin
        st_nxt.addr = host_wr_byte;
      end else if (is_cfg) begin
        if (wr_hit[4]) begin
          // the flag bit slot is reused for parity of the seven data bits
          st_nxt.bank[wr_hit[3:0]] = {^host_wr_byte[6:0], host_wr_byte[6:0]};
        end else if (st_r.addr == ADDR_SOFT_RST) begin
          st_nxt.soft_rst = 1'b1;
        end
      end
    end

    // snapshot on falling sample edge
    if (smp_fall) begin
      if (ctrl_byte[CTRL_HYST_BIT]) begin
        st_nxt.pos = angle_in & rccr_res_mask(res_live);
      end else begin
        st_nxt.pos = angle_in;
      end
      // loop hands over a left-justified two's complement word; stored untouched
      st_nxt.vel = speed_in;
    end

    // register readback
    if (host_rd_req) begin
      st_nxt.rd_valid = 1'b1;
      st_nxt.rd_data = 8'h00;
      case (st_r.addr)
        ADDR_ANGLE_HI: begin
          st_nxt.rd_data = st_r.pos[15:8];
          st_nxt.lo_hold = st_r.pos[7:0];
          st_nxt.lo_pend = 1'b1;
          st_nxt.lo_is_speed = 1'b0;
        end
        ADDR_SPEED_HI: begin
          st_nxt.rd_data = st_r.vel[15:8];
          st_nxt.lo_hold = st_r.vel[7:0];
          st_nxt.lo_pend = 1'b1;
          st_nxt.lo_is_speed = 1'b1;
        end
        ADDR_ANGLE_LO: begin
          st_nxt.rd_data = (st_r.lo_pend && !st_r.lo_is_speed) ? st_r.lo_hold : st_r.pos[7:0];
          st_nxt.lo_pend = 1'b0;
        end
        ADDR_SPEED_LO: begin
          st_nxt.rd_data = (st_r.lo_pend && st_r.lo_is_speed) ? st_r.lo_hold : st_r.vel[7:0];
          st_nxt.lo_pend = 1'b0;
        end
        ADDR_FAULT: begin
          if (is_cfg) begin
            st_nxt.rd_data = st_r.fault;
          end
        end
        default: begin
          if (is_cfg && rd_hit[4]) begin
            st_nxt.rd_data = {sel_byte[PARITY_BIT] ^ (^sel_byte[6:0]), sel_byte[6:0]};
          end
        end
      endcase
    end

    // sticky faults: a new event in the clearing cycle survives
    st_nxt.fault = (st_r.fault & ~{8{flt_clear | st_r.soft_rst}}) | fault_event;
    st_nxt.fault[FLT_PARITY] = st_nxt.fault[FLT_PARITY] | par_err;
    // pins show one condition at a time: loss, then degradation, then tracking
    st_nxt.degrade_n = ~(st_nxt.fault[FLT_LOSS] | st_nxt.fault[FLT_CLIP] | st_nxt.fault[FLT_PARITY]
      | st_nxt.fault[FLT_OVER] | st_nxt.fault[FLT_MISM]);
    st_nxt.track_n = ~(st_nxt.fault[FLT_LOSS] | st_nxt.fault[FLT_CLIP] | st_nxt.fault[FLT_PARITY]
      | ((st_nxt.fault[FLT_TRACK] | st_nxt.fault[FLT_PHASE]) & ~(st_nxt.fault[FLT_OVER]
      | st_nxt.fault[FLT_MISM])));

    // normal-mode parallel word follows the mode pins
    st_nxt.dout = (rccr_mode_t'(st_r.mode_s2) == MODE_VEL) ? st_r.vel : st_r.pos;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      // parity is worked out per entry so an odd default does not raise a parity fault at power-up
      for (int i = 0; i < RW_COUNT; i++) begin
        st_r.bank[i] <= {^RW_RESET[i], RW_RESET[i]};
      end
      st_r.smp_s1 <= 1'b1;
      st_r.smp_s2 <= 1'b1;
      st_r.smp_d <= 1'b1;
      st_r.degrade_n <= 1'b1;
      st_r.track_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // excitation reference; host keeps the word in the specified span
  // ************************************************************
  rccr_exc_nco u_nco (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(st_r.soft_rst),
    .frequency_control_word(st_r.bank[IDX_EXC_FREQ][6:0]),
    .excitation_out(excitation_out)
  );

  assign host_rd_data = st_r.rd_data;
  assign host_rd_valid = st_r.rd_valid;
  assign data_out = st_r.dout;
  assign resolution_code = st_r.res;
  assign config_mode = st_r.cfg;
  assign signal_degradation_n = st_r.degrade_n;
  assign tracking_loss_n = st_r.track_n;

  // ************************************************************
  // checks
  // ************************************************************
  mode_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    config_mode |-> $past(st_r.mode_s2) == MODE_CFG)
    else $error("config mode flag without configuration code");

  write_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (host_wr_valid && !host_wr_byte[TYPE_BIT] && !is_cfg) |=> $stable(st_r.bank))
    else $error("bank changed outside configuration mode");

  fault_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (host_rd_req && !is_cfg && st_r.addr == ADDR_FAULT) |=> host_rd_valid && host_rd_data == 8'h00)
    else $error("fault register read outside configuration mode");

  res_source_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !is_cfg |=> resolution_code == $past(st_r.res_s2))
    else $error("normal mode resolution not taken from pins");

  pos_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !smp_fall |=> $stable(st_r.pos))
    else $error("position changed without sample edge");

  pos_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (smp_fall && ctrl_byte[CTRL_HYST_BIT] && res_live == RES_10) |=> st_r.pos[5:0] == 6'h00)
    else $error("low position bits not cleared at 10 bits");

  pos_full_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (smp_fall && !ctrl_byte[CTRL_HYST_BIT]) |=> st_r.pos == $past(angle_in))
    else $error("position truncated with hysteresis off");

  vel_take_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    smp_fall |=> st_r.vel == $past(speed_in))
    else $error("velocity not loaded on sample edge");

  fault_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (flt_clear && fault_event == 8'h00 && !par_err) |=> st_r.fault == 8'h00 && signal_degradation_n
    && tracking_loss_n)
    else $error("fault not released after configuration read");

  fault_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!tracking_loss_n && !flt_clear && !st_r.soft_rst && fault_event == 8'h00) |=> !tracking_loss_n)
    else $error("tracking fault pin released without fault read");

  pair_snap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (host_rd_req && st_r.addr == ADDR_ANGLE_HI) |=> st_r.lo_hold == $past(st_r.pos[7:0]) && st_r.lo_pend)
    else $error("low byte not frozen with high byte");

  parity_ok_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (host_rd_req && is_cfg && rd_hit[4]) |=> host_rd_data[PARITY_BIT] == 1'b0)
    else $error("parity flagged on intact configuration byte");

  // read answer always comes exactly one cycle after the request
  rd_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    host_rd_req |=> host_rd_valid)
    else $error("read request not answered in the next cycle");

  ctrl_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (host_wr_valid && !host_wr_byte[TYPE_BIT] && is_cfg && st_r.addr == ADDR_MODE_CTRL)
    |=> ctrl_byte[6:0] == $past(host_wr_byte[6:0]))
    else $error("control write in configuration mode lost");

  // parallel word selection follows the synchronised mode code
  vel_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r.mode_s2 == MODE_VEL |=> data_out == $past(st_r.vel))
    else $error("velocity mode does not show velocity");

  rsv_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r.mode_s2 == MODE_RSV |=> !config_mode && data_out == $past(st_r.pos))
    else $error("reserved code not handled as position mode");

  cfg_res_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_cfg |=> resolution_code == $past({ctrl_byte[CTRL_RES_LO_BIT], ctrl_byte[CTRL_RES_HI_BIT]}))
    else $error("configuration resolution not taken from control bits");

  pos_twelve_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (smp_fall && ctrl_byte[CTRL_HYST_BIT] && res_live == RES_12) |=> st_r.pos[3:0] == 4'h0)
    else $error("low position bits not cleared at 12 bits");

  vel_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !smp_fall |=> $stable(st_r.vel))
    else $error("velocity changed without sample edge");

  // loss of signal has top priority and pulls both pins low
  loss_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r.fault[FLT_LOSS] |-> !signal_degradation_n && !tracking_loss_n)
    else $error("signal loss not shown on both fault pins");

endmodule : rccr_top

// file: dv/rccr_host_model.sv
// host-side model of the converter's controller: address, data and read requests.
// assumes the bank answers a read with a one-cycle valid pulse on sys_clk.
`timescale 1ns/1ps
module rccr_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] host_rd_data,
  input wire logic host_rd_valid,
  output logic host_wr_valid,
  output logic [7:0] host_wr_byte,
  output logic host_rd_req
);
  // ************************************************************
  // byte and read tasks
  // ************************************************************
  // idle bus at time zero
  initial begin
    host_wr_valid = 1'b0;
    host_wr_byte = 8'h00;
    host_rd_req = 1'b0;
  end

  // an edge with valid low always passes between two bytes
  task automatic put(input logic [7:0] b);
    @(posedge sys_clk);
    host_wr_valid <= 1'b1;
    host_wr_byte <= b;
    @(posedge sys_clk);
    host_wr_valid <= 1'b0;
    host_wr_byte <= ~b;  // released byte shows no stale value
  endtask : put

  // address byte flagged, data byte carries a clear top bit
  task automatic wr(input logic [7:0] a, input logic [6:0] d);
    put(a | 8'h80);
    put({1'b0, d});
  endtask : wr

  // bounded wait for the answer; unknown if it never comes
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    put(a | 8'h80);
    @(posedge sys_clk);
    host_rd_req <= 1'b1;
    @(posedge sys_clk);
    host_rd_req <= 1'b0;
    d = 8'hXX;
    for (n = 0; n < 3; n++) begin
      #1;
      if (host_rd_valid === 1'b1) begin
        d = host_rd_data;
        break;
      end
      @(posedge sys_clk);
    end
  endtask : rd
endmodule : rccr_host_model

// file: dv/tb_top.sv
// self-checking bench of the converter configuration bank.
// assumes rccr_top and the host model; pins are changed by the bench.
`timescale 1ns/1ps
module tb_top
  import rccr_pkg::*;
;
  logic sys_clk, rst_n, mode_select_lo, mode_select_hi;
  logic resolution_select_lo, resolution_select_hi, sample_n;
  logic [15:0] angle_in, speed_in, data_out;
  logic [7:0] fault_event, host_wr_byte, host_rd_data;
  logic host_wr_valid, host_rd_req, host_rd_valid, config_mode;
  logic [1:0] resolution_code;
  logic signal_degradation_n, tracking_loss_n, excitation_out;
  int failures = 0;
  int checks_done = 0;

  rccr_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .mode_select_lo(mode_select_lo),
    .mode_select_hi(mode_select_hi), .resolution_select_lo(resolution_select_lo),
    .resolution_select_hi(resolution_select_hi), .sample_n(sample_n), .angle_in(angle_in),
    .speed_in(speed_in), .fault_event(fault_event), .host_wr_valid(host_wr_valid),
    .host_wr_byte(host_wr_byte), .host_rd_req(host_rd_req), .host_rd_data(host_rd_data),
    .host_rd_valid(host_rd_valid), .data_out(data_out), .resolution_code(resolution_code),
    .config_mode(config_mode), .signal_degradation_n(signal_degradation_n),
    .tracking_loss_n(tracking_loss_n), .excitation_out(excitation_out));

  rccr_host_model host_u (.sys_clk(sys_clk), .host_rd_data(host_rd_data),
    .host_rd_valid(host_rd_valid), .host_wr_valid(host_wr_valid),
    .host_wr_byte(host_wr_byte), .host_rd_req(host_rd_req));

  // ************************************************************
  // helpers
  // ************************************************************
  // 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // pins go through a synchroniser, so settle a few edges
  task automatic mode(input logic [1:0] m);
    @(posedge sys_clk);
    {mode_select_lo, mode_select_hi} <= m;
    repeat (5) @(posedge sys_clk);
  endtask : mode

  task automatic sample(input logic [15:0] a, input logic [15:0] s);
    @(posedge sys_clk);
    angle_in <= a;
    speed_in <= s;
    sample_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    sample_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : sample

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] h, l;
    host_u.rd(a, h);
    host_u.rd(a + 8'h01, l);
    v = {h, l};
  endtask : rd16

  // cycles up to the next rising edge of the reference
  task automatic rise(output int n);
    logic p;
    #1;
    for (n = 1; n < 2000; n++) begin
      p = excitation_out;
      @(posedge sys_clk);
      #1;
      if (p === 1'b0 && excitation_out === 1'b1) break;
    end
  endtask : rise

  // ************************************************************
  // scenarios
  // ************************************************************
  // watchdog at 40k cycles, well beyond the expected run of some 2k cycles
  initial begin
    #2ms;
    failures++;
    close_out();
  end

  initial begin
    logic [7:0] b;
    logic [15:0] v;
    logic [7:0] da[5] = '{ADDR_SIG_LOSS, ADDR_OVERRANGE, ADDR_MISMATCH, ADDR_EXC_FREQ, ADDR_MODE_CTRL};
    logic [7:0] dv[5] = '{8'h3A, 8'h6C, 8'h0A, 8'h28, 8'h7E};
    int r, n;
    {rst_n, mode_select_lo, mode_select_hi, resolution_select_lo, resolution_select_hi} = 5'h03;
    {sample_n, angle_in, speed_in, fault_event} = {1'b1, 40'h0};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    check({config_mode, signal_degradation_n, tracking_loss_n}, 16'h3);
    mode(2'b11);
    check(config_mode, 16'h1);
    for (r = 0; r < 5; r++) begin
      host_u.rd(da[r], b);
      check(b, dv[r]);
    end
    // word 0x20 gives 19.5 kHz, inside the span, and a period of 2^15/32 clocks
    host_u.wr(ADDR_EXC_FREQ, 7'h20);
    rise(n);
    rise(n);
    check(16'(n), 16'h0400);
    // every resolution code, hysteresis on, pins kept equal
    for (r = 0; r < 4; r++) begin
      {resolution_select_lo, resolution_select_hi} <= r[1:0];
      host_u.wr(ADDR_MODE_CTRL, {5'h1F, r[0], r[1]});
      host_u.rd(ADDR_MODE_CTRL, b);
      check(b, {3'h3, 3'h7, r[0], r[1]});
      sample(16'hFFFF, 16'h0000);
      check(resolution_code, r[1:0]);
      rd16(ADDR_ANGLE_HI, v);
      check(v, 16'hFFFF << (6 - 2 * r));
    end
    // hysteresis off keeps all bits; high read freezes the low byte
    {resolution_select_lo, resolution_select_hi} <= 2'b00;
    host_u.wr(ADDR_MODE_CTRL, 7'h6C);
    sample(16'hABCD, 16'h8000);
    rd16(ADDR_ANGLE_HI, v);
    check(v, 16'hABCD);
    rd16(ADDR_SPEED_HI, v);
    check(v, 16'h8000);
    host_u.rd(ADDR_ANGLE_HI, b);
    sample(16'h1234, 16'h8000);
    host_u.rd(ADDR_ANGLE_LO, b);
    check(b, 8'hCD);
    // latched fault, then normal mode refuses bank access
    @(posedge sys_clk);
    fault_event <= 8'h40;
    @(posedge sys_clk);
    fault_event <= 8'h00;
    repeat (2) @(posedge sys_clk);
    check({signal_degradation_n, tracking_loss_n}, 16'h0);
    mode(2'b00);
    check({config_mode, resolution_code}, 16'h0);
    check(data_out, 16'h1234);
    host_u.wr(ADDR_SIG_LOSS, 7'h11);
    host_u.rd(ADDR_FAULT, b);
    check({b, signal_degradation_n, tracking_loss_n}, 16'h0);
    rd16(ADDR_ANGLE_HI, v);
    check(v, 16'h1234);
    mode(2'b01);
    sample(16'h1234, 16'h7FFF);
    check(data_out, 16'h7FFF);
    mode(2'b10);
    check(config_mode, 16'h0);
    check(data_out, 16'h1234);
    mode(2'b11);
    host_u.rd(ADDR_SIG_LOSS, b);
    check(b, 8'h3A);
    host_u.rd(ADDR_FAULT, b);
    check(b, 8'h40);
    #1;
    check({signal_degradation_n, tracking_loss_n}, 16'h3);
    host_u.rd(ADDR_FAULT, b);
    check(b, 8'h00);
    // soft reset in configuration clears a latched tracking fault and keeps the bank
    @(posedge sys_clk);
    fault_event <= 8'h08;
    @(posedge sys_clk);
    fault_event <= 8'h00;
    repeat (2) @(posedge sys_clk);
    check({signal_degradation_n, tracking_loss_n}, 16'h2);
    host_u.wr(ADDR_SOFT_RST, 7'h00);
    repeat (2) @(posedge sys_clk);
    check({signal_degradation_n, tracking_loss_n}, 16'h3);
    host_u.rd(ADDR_EXC_FREQ, b);
    check(b, 8'h20);
    close_out();
  end
endmodule : tb_top
